// ### ebf_defs.svh
`ifndef EBF_DEFS_SVH
`define EBF_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define EBF_REG_CTRL 5'h00
`define EBF_REG_FULL_THR 5'h04
`define EBF_REG_AFULL_THR 5'h08
`define EBF_REG_AEMPTY_THR 5'h0C
`define EBF_REG_STATUS 5'h10
`define EBF_REG_IRQ_STAT 5'h14
`define EBF_REG_IRQ_MASK 5'h18

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define EBF_CTRL_MODE 0
`define EBF_CTRL_WMODE_LSB 1
`define EBF_CTRL_WSEL_LSB 3
`define EBF_CTRL_RSEL_LSB 6
`define EBF_CTRL_W 9
`define EBF_CTRL_RST 9'h0D8
`define EBF_SEL_W 3
`define EBF_AEMPTY_RST 1
`define EBF_AFULL_MARGIN 1

// ****************************************************************
// status and interrupt bits
// ****************************************************************
`define EBF_STAT_FULL 0
`define EBF_STAT_AFULL 1
`define EBF_STAT_AEMPTY 2
`define EBF_STAT_EMPTY 3
`define EBF_STAT_COUNT_LSB 16
`define EBF_IRQ_FULL 0
`define EBF_IRQ_AFULL 1
`define EBF_IRQ_AEMPTY 2
`define EBF_IRQ_EMPTY 3
`define EBF_IRQ_OVERFLOW 4
`define EBF_IRQ_UNDERFLOW 5
`define EBF_IRQ_W 6

`endif

// ### ebf_pkg.sv
package ebf_pkg;

    // write behaviour of the shared memory port
    typedef enum logic [1:0] {
        EBF_WM_NORMAL = 2'h0,
        EBF_WM_THROUGH = 2'h1,
        EBF_WM_RBW = 2'h3
    } ebf_wmode_t;

    // what the memory is used as
    typedef enum logic {
        EBF_MODE_RAM = 1'h0,
        EBF_MODE_FIFO = 1'h1
    } ebf_opmode_t;

endpackage

// ### ebf_ram.sv
`timescale 1ns/1ps

module ebf_ram #(
    parameter int AW = 9,
    parameter int DW = 16,
    parameter int BW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // port a: write with selectable output behaviour
    input wire logic a_rst,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [BW-1:0] a_be,
    input wire ebf_pkg::ebf_wmode_t a_mode,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_din,
    output logic [DW-1:0] a_dout,
    // port b: read only
    input wire logic b_rst,
    input wire logic b_en,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_dout
);

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] a_old;
    logic [DW-1:0] a_word;
    logic [DW-1:0] a_dout_reg;
    logic [DW-1:0] a_dout_next;
    logic [DW-1:0] b_dout_reg;

    assign a_old = mem[a_addr];

    // byte lanes not enabled keep their old contents
    genvar g;
    for (g = 0; g < DW; g++) begin : g_lane
        assign a_word[g] = a_be[g / 8] ? a_din[g] : a_old[g];
    end

    // normal holds the output on a write
    assign a_dout_next = !a_we ? a_old :
        (a_mode == ebf_pkg::EBF_WM_THROUGH) ? a_din :
        (a_mode == ebf_pkg::EBF_WM_RBW) ? a_old :
        a_dout_reg;

    // no reset on the array: contents are only meaningful once written
    always_ff @(posedge clk) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_dout_reg <= '0;
        end else if (a_rst) begin
            a_dout_reg <= '0;
        end else if (a_en) begin
            a_dout_reg <= a_dout_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            b_dout_reg <= '0;
        end else if (b_rst) begin
            b_dout_reg <= '0;
        end else if (b_en) begin
            b_dout_reg <= mem[b_addr];
        end
    end

    assign a_dout = a_dout_reg;
    assign b_dout = b_dout_reg;

    property p_normal_hold;
        @(posedge clk) disable iff (!rst_n)
        (a_en && a_we && !a_rst && a_mode == ebf_pkg::EBF_WM_NORMAL)
            |=> $stable(a_dout_reg);
    endproperty
    a_normal_hold: assert property (p_normal_hold)
        else $error("normal write changed the output");

    property p_write_through;
        @(posedge clk) disable iff (!rst_n)
        (a_en && a_we && !a_rst && a_mode == ebf_pkg::EBF_WM_THROUGH)
            |=> (a_dout_reg == $past(a_din));
    endproperty
    a_write_through: assert property (p_write_through)
        else $error("write-through output is not the written data");

    property p_read_before_write;
        @(posedge clk) disable iff (!rst_n)
        (a_en && a_we && !a_rst && a_mode == ebf_pkg::EBF_WM_RBW)
            |=> (a_dout_reg == $past(a_old));
    endproperty
    a_read_before_write: assert property (p_read_before_write)
        else $error("read-before-write output is not the old contents");

endmodule // ebf_ram

// ### ebf_top.sv
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "ebf_defs.svh"

// Summary of operation
// - normal write leaves port output unchanged
// - write-through shows written data on output
// - read-before-write shows old contents on output
// - fifo has independent write and read ports
// - full and almost-full registered on write side
// - empty and almost-empty registered on read side
// - thresholds clamped; empty threshold fixed zero
// - global fifo reset clears pointers and flags
// - read pointer reset clears only read pointer
// - chain inputs act as select bit two
module ebf_top #(
    parameter int AW = 9,
    parameter int DW = 16,
    parameter int BW = DW / 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // single port memory
    input wire logic ram_ce,
    input wire logic ram_oce,
    input wire logic ram_rst,
    input wire logic ram_select,
    input wire logic ram_we,
    input wire logic [BW-1:0] ram_byte_en,
    input wire logic [AW-1:0] ram_addr,
    input wire logic [DW-1:0] ram_din,
    output logic [DW-1:0] ram_dout,
    // fifo control
    input wire logic fifo_rst,
    input wire logic rd_ptr_reset,
    // fifo write port
    input wire logic wr_clk_en,
    input wire logic wr_en,
    input wire logic [1:0] wr_select,
    input wire logic full_chain_in,
    input wire logic [DW-1:0] wr_data,
    // fifo read port
    input wire logic rd_clk_en,
    input wire logic rd_en,
    input wire logic out_clk_en,
    input wire logic [1:0] rd_select,
    input wire logic empty_chain_in,
    output logic [DW-1:0] rd_data,
    // fifo flags
    output logic full_flag,
    output logic almost_full_flag,
    output logic almost_empty_flag,
    output logic empty_flag
);

    localparam int CW = AW + 1;
    localparam logic [AW-1:0] FULL_MAX = '1;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // threshold writes are pulled into 1..hi
    function automatic logic [AW-1:0] clamp_thr(
        input logic [31:0] v,
        input logic [AW-1:0] hi
    );
        logic [AW-1:0] r;
        r = (v > 32'(hi)) ? hi : v[AW-1:0];
        if (r == '0) begin
            r = AW'(1);
        end
        return r;
    endfunction

    function automatic logic at_least(
        input logic [CW-1:0] cnt,
        input logic [AW-1:0] thr
    );
        return cnt >= {1'b0, thr};
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`EBF_CTRL_W-1:0] ctrl_reg;
    logic [AW-1:0] full_thr_reg;
    logic [AW-1:0] afull_thr_reg;
    logic [AW-1:0] aempty_thr_reg;
    logic [`EBF_IRQ_W-1:0] irq_stat_reg;
    logic [`EBF_IRQ_W-1:0] irq_stat_next;
    logic [`EBF_IRQ_W-1:0] irq_mask_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [CW-1:0] wptr_reg;
    logic [CW-1:0] wptr_next;
    logic [CW-1:0] rptr_reg;
    logic [CW-1:0] rptr_next;
    logic full_reg;
    logic afull_reg;
    logic aempty_reg;
    logic empty_reg;
    logic [DW-1:0] ram_dout_reg;
    logic [DW-1:0] rd_data_reg;

    // ****************************************************************
    // register bus decode
    // ****************************************************************
    logic bus_req;
    logic bus_wr;
    logic bus_rd_cap;
    logic [31:0] rd_word;
    logic [CW-1:0] cnt_now;
    logic [`EBF_IRQ_W-1:0] irq_clr;

    // one wait cycle on every access; data is staged in between
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign bus_wr = avs_write & ack_reg;
    assign bus_rd_cap = avs_read & ~ack_reg;
    assign cnt_now = wptr_reg - rptr_reg;

    assign rd_word =
        (avs_address == `EBF_REG_CTRL) ? 32'(ctrl_reg) :
        (avs_address == `EBF_REG_FULL_THR) ? 32'(full_thr_reg) :
        (avs_address == `EBF_REG_AFULL_THR) ? 32'(afull_thr_reg) :
        (avs_address == `EBF_REG_AEMPTY_THR) ? 32'(aempty_thr_reg) :
        (avs_address == `EBF_REG_STATUS) ?
            {16'(cnt_now), 12'h000, empty_reg, aempty_reg,
             afull_reg, full_reg} :
        (avs_address == `EBF_REG_IRQ_STAT) ? 32'(irq_stat_reg) :
        (avs_address == `EBF_REG_IRQ_MASK) ? 32'(irq_mask_reg) :
        32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_rd_cap) begin
                rdata_reg <= rd_word;
            end
        end
    end

    assign avs_readdata = rdata_reg;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `EBF_CTRL_RST;
            full_thr_reg <= FULL_MAX;
            afull_thr_reg <= FULL_MAX - AW'(`EBF_AFULL_MARGIN);
            aempty_thr_reg <= AW'(`EBF_AEMPTY_RST);
            irq_mask_reg <= '0;
        end else if (bus_wr) begin
            case (avs_address)
                `EBF_REG_CTRL: begin
                    ctrl_reg <= avs_writedata[`EBF_CTRL_W-1:0];
                end
                `EBF_REG_FULL_THR: begin
                    full_thr_reg <= clamp_thr(avs_writedata, FULL_MAX);
                end
                `EBF_REG_AFULL_THR: begin
                    afull_thr_reg <= clamp_thr(avs_writedata,
                        full_thr_reg - AW'(1));
                end
                `EBF_REG_AEMPTY_THR: begin
                    aempty_thr_reg <= clamp_thr(avs_writedata,
                        full_thr_reg - AW'(1));
                end
                `EBF_REG_IRQ_MASK: begin
                    irq_mask_reg <= avs_writedata[`EBF_IRQ_W-1:0];
                end
                default: begin
                    irq_mask_reg <= irq_mask_reg;
                end
            endcase
        end
    end

    // ****************************************************************
    // fifo pointers and flags
    // ****************************************************************
    logic fifo_mode;
    ebf_pkg::ebf_wmode_t wmode;
    logic wr_cs;
    logic rd_cs;
    logic wr_req;
    logic rd_req;
    logic wr_go;
    logic rd_go;
    logic [CW-1:0] cnt_next;
    logic full_next;
    logic afull_next;
    logic aempty_next;
    logic empty_next;

    assign fifo_mode = ctrl_reg[`EBF_CTRL_MODE];
    assign wmode = ebf_pkg::ebf_wmode_t'(ctrl_reg[`EBF_CTRL_WMODE_LSB +: 2]);
    assign wr_cs = {full_chain_in, wr_select} ==
        ctrl_reg[`EBF_CTRL_WSEL_LSB +: `EBF_SEL_W];
    assign rd_cs = {empty_chain_in, rd_select} ==
        ctrl_reg[`EBF_CTRL_RSEL_LSB +: `EBF_SEL_W];
    assign wr_req = fifo_mode & wr_clk_en & wr_en & wr_cs;
    assign rd_req = fifo_mode & rd_clk_en & rd_en & rd_cs;
    // flags are current, so a request in the cycle after the fill is blocked
    assign wr_go = wr_req & ~full_reg & ~fifo_rst;
    assign rd_go = rd_req & ~empty_reg & ~fifo_rst & ~rd_ptr_reset;

    assign wptr_next = fifo_rst ? '0 : wptr_reg + CW'(wr_go);
    assign rptr_next = (fifo_rst | rd_ptr_reset) ? '0 :
        rptr_reg + CW'(rd_go);
    assign cnt_next = wptr_next - rptr_next;
    assign full_next = at_least(cnt_next, full_thr_reg);
    assign afull_next = at_least(cnt_next, afull_thr_reg);
    assign aempty_next = ~at_least(cnt_next, aempty_thr_reg + AW'(1));
    assign empty_next = cnt_next == '0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            full_reg <= 1'b0;
            afull_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            full_reg <= full_next;
            afull_reg <= afull_next;
        end
    end

    // a read pointer reset can leave the count above the depth;
    // software must drain or reset the whole fifo after it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rptr_reg <= '0;
            aempty_reg <= 1'b1;
            empty_reg <= 1'b1;
        end else begin
            rptr_reg <= rptr_next;
            aempty_reg <= aempty_next;
            empty_reg <= empty_next;
        end
    end

    assign full_flag = full_reg;
    assign almost_full_flag = afull_reg;
    assign almost_empty_flag = aempty_reg;
    assign empty_flag = empty_reg;

    // ****************************************************************
    // memory and output registers
    // ****************************************************************
    logic a_en;
    logic a_we;
    logic [BW-1:0] a_be;
    ebf_pkg::ebf_wmode_t a_mode;
    logic [AW-1:0] a_addr;
    logic [DW-1:0] a_din;
    logic [DW-1:0] a_dout;
    logic [DW-1:0] b_dout;

    // fifo mode borrows port a for writes with its output unused
    assign a_en = fifo_mode ? wr_go : (ram_ce & ram_select);
    assign a_we = fifo_mode ? 1'b1 : ram_we;
    assign a_be = fifo_mode ? '1 : ram_byte_en;
    assign a_mode = fifo_mode ? ebf_pkg::EBF_WM_NORMAL : wmode;
    assign a_addr = fifo_mode ? wptr_reg[AW-1:0] : ram_addr;
    assign a_din = fifo_mode ? wr_data : ram_din;

    ebf_ram #(
        .AW(AW),
        .DW(DW),
        .BW(BW)
    ) u_ram (
        .clk(clk),
        .rst_n(rst_n),
        .a_rst(ram_rst),
        .a_en(a_en),
        .a_we(a_we),
        .a_be(a_be),
        .a_mode(a_mode),
        .a_addr(a_addr),
        .a_din(a_din),
        .a_dout(a_dout),
        .b_rst(fifo_rst),
        .b_en(rd_go),
        .b_addr(rptr_reg[AW-1:0]),
        .b_dout(b_dout)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_dout_reg <= '0;
            rd_data_reg <= '0;
        end else begin
            if (ram_rst) begin
                ram_dout_reg <= '0;
            end else if (ram_oce) begin
                ram_dout_reg <= a_dout;
            end
            if (fifo_rst) begin
                rd_data_reg <= '0;
            end else if (out_clk_en) begin
                rd_data_reg <= b_dout;
            end
        end
    end

    assign ram_dout = ram_dout_reg;
    assign rd_data = rd_data_reg;

    // ****************************************************************
    // interrupts
    // ****************************************************************
    logic [`EBF_IRQ_W-1:0] irq_ev;

    assign irq_ev[`EBF_IRQ_FULL] = full_next & ~full_reg;
    assign irq_ev[`EBF_IRQ_AFULL] = afull_next & ~afull_reg;
    assign irq_ev[`EBF_IRQ_AEMPTY] = aempty_next & ~aempty_reg;
    assign irq_ev[`EBF_IRQ_EMPTY] = empty_next & ~empty_reg;
    assign irq_ev[`EBF_IRQ_OVERFLOW] = wr_req & full_reg;
    assign irq_ev[`EBF_IRQ_UNDERFLOW] = rd_req & empty_reg;
    assign irq_clr = (bus_wr && avs_address == `EBF_REG_IRQ_STAT) ?
        avs_writedata[`EBF_IRQ_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_full_blocks_write;
        @(posedge clk) disable iff (!rst_n)
        (wr_req && full_reg && !fifo_rst) |=> $stable(wptr_reg);
    endproperty
    a_full_blocks_write: assert property (p_full_blocks_write)
        else $error("write pointer moved while full");

    property p_empty_blocks_read;
        @(posedge clk) disable iff (!rst_n)
        (rd_req && empty_reg && !fifo_rst && !rd_ptr_reset)
            |=> $stable(rptr_reg);
    endproperty
    a_empty_blocks_read: assert property (p_empty_blocks_read)
        else $error("read pointer moved while empty");

    property p_global_reset;
        @(posedge clk) disable iff (!rst_n)
        fifo_rst |=> (wptr_reg == '0 && rptr_reg == '0 && empty_reg
            && aempty_reg && !full_reg && rd_data_reg == '0);
    endproperty
    a_global_reset: assert property (p_global_reset)
        else $error("fifo reset left state behind");

    property p_rd_ptr_reset;
        @(posedge clk) disable iff (!rst_n)
        (rd_ptr_reset && !fifo_rst)
            |=> (rptr_reg == '0 && wptr_reg == $past(wptr_next));
    endproperty
    a_rd_ptr_reset: assert property (p_rd_ptr_reset)
        else $error("read pointer reset misbehaved");

    property p_full_level;
        @(posedge clk) disable iff (!rst_n)
        full_reg == (cnt_now >= {1'b0, $past(full_thr_reg)});
    endproperty
    a_full_level: assert property (p_full_level)
        else $error("full flag does not match the count");

    property p_almost_empty_level;
        @(posedge clk) disable iff (!rst_n)
        aempty_reg == (cnt_now <= {1'b0, $past(aempty_thr_reg)});
    endproperty
    a_almost_empty_level: assert property (p_almost_empty_level)
        else $error("almost empty flag does not match the count");

    property p_select_gates_write;
        @(posedge clk) disable iff (!rst_n)
        (!fifo_rst && fifo_mode && wr_clk_en && wr_en && !full_reg
            && {full_chain_in, wr_select} !=
               ctrl_reg[`EBF_CTRL_WSEL_LSB +: `EBF_SEL_W])
            |=> $stable(wptr_reg);
    endproperty
    a_select_gates_write: assert property (p_select_gates_write)
        else $error("unselected write was taken");

    property p_thr_range;
        @(posedge clk) disable iff (!rst_n)
        bus_wr && avs_address == `EBF_REG_FULL_THR
            |=> (full_thr_reg != '0);
    endproperty
    a_thr_range: assert property (p_thr_range)
        else $error("full threshold left its range");

    property p_one_wait;
        @(posedge clk) disable iff (!rst_n)
        (bus_req && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer took more than one wait cycle");

endmodule // ebf_top

// ### ebf_top_tb.sv
`timescale 1ns/1ps
`include "ebf_defs.svh"

module ebf_top_tb;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic ram_ce, ram_we, fifo_rst, rd_ptr_reset, ram_rst, ech;
    logic [3:0] ram_addr;
    logic [15:0] ram_din, ram_dout, rd_data, wdat, wr_data, exp_rd, va, vb;
    logic wr_clk_en, wr_en, rd_clk_en, rd_en, out_clk_en;
    logic full_flag, almost_full_flag, almost_empty_flag, empty_flag;
    logic [1:0] wsel, ram_be, rsel;
    logic chain_in, do_wr, do_rd, slow;
    logic [15:0] mem [16];
    int bad_count, total_checks, wp, rp, seed, i, m;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ebf_top #(.AW(4), .DW(16)) DUT (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .ram_ce(ram_ce), .ram_oce(1'b1), .ram_rst(ram_rst),
        .ram_select(ram_ce), .ram_we(ram_we), .ram_byte_en(ram_be),
        .ram_addr(ram_addr), .ram_din(ram_din), .ram_dout(ram_dout),
        .fifo_rst(fifo_rst), .rd_ptr_reset(rd_ptr_reset),
        .wr_clk_en(wr_clk_en), .wr_en(wr_en), .wr_select(wsel),
        .full_chain_in(chain_in), .wr_data(wr_data),
        .rd_clk_en(rd_clk_en), .rd_en(rd_en), .out_clk_en(out_clk_en),
        .rd_select(rsel), .empty_chain_in(ech), .rd_data(rd_data),
        .full_flag(full_flag), .almost_full_flag(almost_full_flag),
        .almost_empty_flag(almost_empty_flag), .empty_flag(empty_flag));

    ebf_user #(.DW(16)) user (.clk(clk), .rst_n(rst_n), .do_wr(do_wr),
        .do_rd(do_rd), .slow(slow), .wdat(wdat), .wr_clk_en(wr_clk_en),
        .wr_en(wr_en), .wr_data(wr_data), .rd_clk_en(rd_clk_en),
        .rd_en(rd_en), .out_clk_en(out_clk_en));

    // ****************
    // checks and bus
    // ****************
    task automatic finish_test;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered one edge late so a lowered strobe is never re-raised at once
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            finish_test();
        end
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic irq_chk(input logic [31:0] mask, input logic e);
        bus(1'b1, `EBF_REG_IRQ_MASK, mask);
        @(posedge clk);
        chk(irq, e);
    endtask

    // ****************
    // fifo model
    // ****************
    task automatic flags;
        int c;
        logic [3:0] g;
        logic [3:0] e;
        c = wp - rp;
        g = {full_flag, almost_full_flag, almost_empty_flag, empty_flag};
        e = {c >= 15, c >= 14, c <= 1, c == 0};
        chk(g, e);
    endtask

    task automatic push(input logic [15:0] v);
        @(posedge clk);
        do_wr <= 1'b1;
        wdat <= v;
        @(posedge clk);
        do_wr <= 1'b0;
        if (wp - rp < 15 && !chain_in) begin
            mem[wp % 16] = v;
            wp++;
        end
        repeat (2) @(posedge clk);
        flags();
    endtask

    task automatic pop;
        @(posedge clk);
        do_rd <= 1'b1;
        slow <= 1'($random(seed));
        @(posedge clk);
        do_rd <= 1'b0;
        if (wp != rp && {ech, rsel} == 3'h3) begin
            exp_rd = mem[rp % 16];
            rp++;
        end
        repeat (4) @(posedge clk);
        chk(rd_data, exp_rd);
        flags();
    endtask

    task automatic clear(input logic g);
        @(posedge clk);
        fifo_rst <= g;
        rd_ptr_reset <= !g;
        @(posedge clk);
        fifo_rst <= 1'b0;
        rd_ptr_reset <= 1'b0;
        @(posedge clk);
        rp = 0;
        if (g) begin
            wp = 0;
            exp_rd = '0;
        end
        flags();
    endtask

    task automatic ram(input logic w, input logic [3:0] a,
                       input logic [15:0] d);
        @(posedge clk);
        ram_ce <= 1'b1;
        ram_we <= w;
        ram_addr <= a;
        ram_din <= d;
        @(posedge clk);
        ram_ce <= 1'b0;
        ram_we <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        seed = 32'h4967;
        rst_n = 1'b0;
        {avs_read, avs_write, ram_ce, ram_we, fifo_rst, rd_ptr_reset} = '0;
        {do_wr, do_rd, slow, chain_in, ram_rst, ech} = '0;
        {avs_address, avs_writedata, ram_addr, ram_din, wdat} = '0;
        wsel = 2'h3;
        {ram_be, rsel} = 4'hF;
        exp_rd = '0;
        {wp, rp, bad_count, total_checks} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        flags();
        rd(`EBF_REG_CTRL, 32'h0D8);
        rd(`EBF_REG_FULL_THR, 32'hF);
        rd(`EBF_REG_AFULL_THR, 32'hE);
        rd(`EBF_REG_AEMPTY_THR, 32'h1);
        rd(`EBF_REG_STATUS, 32'hC);
        rd(`EBF_REG_IRQ_MASK, 32'h0);
        rd(5'h1C, 32'h0);
        bus(1'b1, `EBF_REG_FULL_THR, 32'h0);
        rd(`EBF_REG_FULL_THR, 32'h1);
        bus(1'b1, `EBF_REG_FULL_THR, 32'hFF);
        rd(`EBF_REG_FULL_THR, 32'hF);
        bus(1'b1, `EBF_REG_CTRL, 32'h0D9);
        chain_in <= 1'b1;
        push(16'($random(seed)));
        chain_in <= 1'b0;
        for (i = 0; i < 17; i++) push(16'($random(seed)));
        irq_chk(32'h10, 1'b1);
        irq_chk(32'h0, 1'b0);
        bus(1'b1, `EBF_REG_IRQ_STAT, 32'h3F);
        rd(`EBF_REG_IRQ_STAT, 32'h0);
        {ech, rsel} <= 3'h7;
        pop();
        {ech, rsel} <= 3'h3;
        for (i = 0; i < 17; i++) pop();
        bus(1'b0, `EBF_REG_IRQ_STAT, 32'h0);
        chk(rdat[5], 1'b1);
        clear(1'b1);
        for (i = 0; i < 3; i++) push(16'($random(seed)));
        pop();
        clear(1'b0);
        for (i = 0; i < 3; i++) pop();
        clear(1'b1);
        for (m = 0; m < 4; m++) begin
            bus(1'b1, `EBF_REG_CTRL, 32'h0D8 | (32'(m) << 1));
            va = 16'($random(seed));
            vb = 16'($random(seed));
            wdat = 16'($random(seed));
            ram(1'b1, 4'h2, va);
            ram(1'b1, 4'h5, vb);
            ram(1'b0, 4'h5, 16'h0);
            chk(ram_dout, vb);
            ram_be <= 2'h1;
            ram(1'b1, 4'h2, wdat);
            ram_be <= 2'h3;
            chk(ram_dout, m == 1 ? wdat : (m == 3 ? va : vb));
            ram(1'b0, 4'h2, 16'h0);
            chk(ram_dout, {va[15:8], wdat[7:0]});
        end
        ram_rst <= 1'b1;
        @(posedge clk);
        ram_rst <= 1'b0;
        @(posedge clk);
        chk(ram_dout, 16'h0);
        finish_test();
    end
endmodule // ebf_top_tb

// ### ebf_user.sv
`timescale 1ns/1ps

// ************************
// user logic on fifo ports
// ************************
module ebf_user #(
    parameter int DW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // commands
    input wire logic do_wr,
    input wire logic do_rd,
    input wire logic slow,
    input wire logic [DW-1:0] wdat,
    // fifo ports
    output logic wr_clk_en,
    output logic wr_en,
    output logic [DW-1:0] wr_data,
    output logic rd_clk_en,
    output logic rd_en,
    output logic out_clk_en
);
    logic late_reg;

    // idle data inverted: a stale word never looks fresh
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_clk_en <= 1'b0;
            wr_en <= 1'b0;
            wr_data <= '0;
            rd_clk_en <= 1'b0;
            rd_en <= 1'b0;
            late_reg <= 1'b0;
            out_clk_en <= 1'b0;
        end else begin
            wr_clk_en <= do_wr;
            wr_en <= do_wr;
            wr_data <= do_wr ? wdat : ~wr_data;
            rd_clk_en <= do_rd;
            rd_en <= do_rd;
            late_reg <= rd_en;
            out_clk_en <= slow ? late_reg : rd_en;
        end
    end
endmodule // ebf_user
